// [core/iqgm_pkg.sv]
/*
 * Constants, types and helper functions for the quadrature gain and coarse mixer block.
 * Assumes a 32-bit classic Wishbone register bus and 16-bit signed I/Q samples.
 */
// Functional notes
// [RULE_01] In-phase samples scaled by 11-bit unsigned gain.
// [RULE_02] Quadrature samples scaled by separate 11-bit gain.
// [RULE_03] Gain binary point between bits 9 and 10.
// [RULE_04] Mixer bit 15 Fs/8, bit 14 Fs/4.
// [RULE_05] Mixer bit 13 Fs/2, bit 12 minus Fs/4.
// [RULE_06] Selected mixer stages combine into n times Fs/8.
// [RULE_07] Mixer select field resets to all zeros.
// [RULE_08] In-phase gain register resets to 0x0400.
// [RULE_09] Mixer and quadrature gain register resets 0x0400.
// [RULE_10] Reserved word at 0x0B resets to zero.
// [RULE_11] Gains take effect only on phase register write.
// [RULE_12] Round and saturate products to 16 bits.
package iqgm_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IQGM_IDX_RSVD_B = 8'h0b;
	localparam logic [7:0] IQGM_IDX_IGAIN = 8'h0c;
	localparam logic [7:0] IQGM_IDX_MIXQ = 8'h0d;
	localparam logic [7:0] IQGM_IDX_RSVD_E = 8'h0e;
	localparam logic [7:0] IQGM_IDX_PHASE = 8'h10;
	localparam logic [7:0] IQGM_IDX_STATUS = 8'h1e;
	localparam int IQGM_ADR_LSB = 2;

	// Reset values.
	localparam logic [15:0] IQGM_RST_RSVD_B = 16'h0000;
	localparam logic [15:0] IQGM_RST_IGAIN = 16'h0400;
	localparam logic [15:0] IQGM_RST_MIXQ = 16'h0400;
	localparam logic [15:0] IQGM_RST_RSVD_E = 16'h0400;
	localparam logic [15:0] IQGM_RST_PHASE = 16'h0000;

	// Field layout.
	localparam int IQGM_GAIN_W = 11;
	localparam int IQGM_GAIN_FRAC = 10;
	localparam int IQGM_MIX_LSB = 12;
	localparam int IQGM_MIX_W = 4;
	localparam int IQGM_MIX_FS8 = 3;
	localparam int IQGM_MIX_FS4 = 2;
	localparam int IQGM_MIX_FS2 = 1;
	localparam int IQGM_MIX_NFS4 = 0;
	localparam int IQGM_PHASE_W = 14;
	localparam int IQGM_STAT_QGAIN_LSB = 16;
	localparam int IQGM_STAT_PHASE_LSB = 28;

	// Writable bits of the stored words; reserved bits are never stored and read zero.
	localparam logic [15:0] IQGM_KEEP_IGAIN = 16'h07ff;
	localparam logic [15:0] IQGM_KEEP_MIXQ = 16'hf7ff;
	localparam logic [15:0] IQGM_KEEP_PHASE = 16'h3fff;

	// Mixer phase steps in units of Fs/8, modulo eight.
	localparam logic [2:0] IQGM_STEP_FS8 = 3'h1;
	localparam logic [2:0] IQGM_STEP_FS4 = 3'h2;
	localparam logic [2:0] IQGM_STEP_FS2 = 3'h4;
	localparam logic [2:0] IQGM_STEP_NFS4 = 3'h6;

	// Cosine of 45 degrees in Q15, its fraction width and the sample width.
	localparam logic signed [16:0] IQGM_COS45 = 17'sh05a82;
	localparam int IQGM_COS_FRAC = 15;
	localparam int IQGM_SAMPLE_W = 16;

	// Bus slave states, one-hot.
	typedef enum logic [1:0] {
		IQGM_BUS_IDLE = 2'b01,
		IQGM_BUS_ACK = 2'b10
	} iqgm_bus_state_type;

	// Clamps a wide signed value to the 16-bit sample range.
	function automatic logic signed [15:0] iqgm_sat16(input logic signed [33:0] v);
		logic signed [15:0] r;
		r = 16'sh0000;
		if (v > 34'sh0_0000_7fff) begin
			r = 16'sh7fff;
		end else if (v < -34'sh0_0000_8000) begin
			r = -16'sh8000;
		end else begin
			r = v[15:0];
		end
		return r;
	endfunction

endpackage

// [core/iqgm_gain_scale.sv]
/*
 * One channel of gain correction: signed sample times unsigned 11-bit gain.
 * Assumes the gain word is stable while samples flow; output is registered.
 */
`timescale 1ns/1ns
module iqgm_gain_scale (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Sample and gain.
	input wire logic signed [15:0] sample_i,
	input wire logic [10:0] gain_i,
	output logic signed [15:0] sample_o
);
	import iqgm_pkg::*;

	logic signed [27:0] product;
	logic signed [27:0] rounded;
	logic signed [15:0] sample_next;
	logic signed [15:0] sample_reg;

	// The gain is zero-extended so it multiplies as a positive value.
	assign product = sample_i * $signed({1'b0, gain_i}); // [RULE_01] [RULE_02]
	// Half an output step is added before the shift so the result rounds.
	assign rounded = product + 28'sd512; // [RULE_12]
	// Shifting by ten places the binary point between bits 9 and 10.
	assign sample_next = iqgm_sat16(34'(rounded >>> IQGM_GAIN_FRAC)); // [RULE_03] [RULE_12]

	// Output stage register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_reg <= 16'sh0000;
		end else begin
			sample_reg <= sample_next;
		end
	end

	assign sample_o = sample_reg;
endmodule

// [core/iqgm_coarse_mixer.sv]
/*
 * Coarse mixer: rotates each I/Q sample by a multiple of 45 degrees per sample.
 * Assumes valid marks each new sample; the phase advances only on valid samples.
 */
`timescale 1ns/1ns
module iqgm_coarse_mixer (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic [3:0] mode_i,
	// Samples in.
	input wire logic valid_i,
	input wire logic signed [15:0] inphase_i,
	input wire logic signed [15:0] quad_i,
	// Samples out.
	output logic signed [15:0] inphase_o,
	output logic signed [15:0] quad_o,
	output logic [2:0] phase_o
);
	import iqgm_pkg::*;

	logic [2:0] step;
	logic [2:0] phase_reg;
	logic [2:0] phase_next;
	logic signed [33:0] diff_prod;
	logic signed [33:0] sum_prod;
	logic signed [15:0] odd_i;
	logic signed [15:0] odd_q;
	logic signed [15:0] base_i;
	logic signed [15:0] base_q;
	logic signed [15:0] neg_i;
	logic signed [15:0] neg_q;
	logic signed [15:0] inphase_next;
	logic signed [15:0] quad_next;
	logic signed [15:0] inphase_reg;
	logic signed [15:0] quad_reg;

	// Each enabled stage adds its step; the sum wraps at a full turn.
	assign step = (mode_i[IQGM_MIX_FS8] ? IQGM_STEP_FS8 : 3'h0)
		+ (mode_i[IQGM_MIX_FS4] ? IQGM_STEP_FS4 : 3'h0)
		+ (mode_i[IQGM_MIX_FS2] ? IQGM_STEP_FS2 : 3'h0)
		+ (mode_i[IQGM_MIX_NFS4] ? IQGM_STEP_NFS4 : 3'h0); // [RULE_04] [RULE_05] [RULE_06]
	assign phase_next = valid_i ? phase_reg + step : phase_reg;

	// An odd phase first turns the sample by 45 degrees with rounding.
	assign diff_prod = (34'(inphase_i) - 34'(quad_i)) * 34'(IQGM_COS45)
		+ (34'sd1 <<< (IQGM_COS_FRAC - 1));
	assign sum_prod = (34'(inphase_i) + 34'(quad_i)) * 34'(IQGM_COS45)
		+ (34'sd1 <<< (IQGM_COS_FRAC - 1));
	assign odd_i = iqgm_sat16(diff_prod >>> IQGM_COS_FRAC);
	assign odd_q = iqgm_sat16(sum_prod >>> IQGM_COS_FRAC);
	assign base_i = phase_reg[0] ? odd_i : inphase_i;
	assign base_q = phase_reg[0] ? odd_q : quad_i;
	assign neg_i = iqgm_sat16(-34'(base_i));
	assign neg_q = iqgm_sat16(-34'(base_q));

	// Quarter turns are swaps and negations; a negated -32768 saturates to 32767.
	always_comb begin
		case (phase_reg[2:1])
			2'h1: begin
				inphase_next = neg_q;
				quad_next = base_i;
			end
			2'h2: begin
				inphase_next = neg_i;
				quad_next = neg_q;
			end
			2'h3: begin
				inphase_next = base_q;
				quad_next = neg_i;
			end
			default: begin
				inphase_next = base_i;
				quad_next = base_q;
			end
		endcase
	end

	// Phase accumulator and output registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg <= 3'h0;
			inphase_reg <= 16'sh0000;
			quad_reg <= 16'sh0000;
		end else begin
			phase_reg <= phase_next;
			inphase_reg <= inphase_next;
			quad_reg <= quad_next;
		end
	end

	assign inphase_o = inphase_reg;
	assign quad_o = quad_reg;
	assign phase_o = phase_reg;
endmodule

// [core/iqgm_top.sv]
/*
 * Quadrature gain correction and coarse mixer with its Wishbone register file.
 * Assumes a classic Wishbone master on the same clock and an upstream source
 * that presents one I/Q sample per cycle with a valid strobe.
 */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module iqgm_top (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Samples from the interpolation datapath.
	input wire logic sample_valid_i,
	input wire logic signed [15:0] inphase_i,
	input wire logic signed [15:0] quad_i,
	// Samples toward the two converters.
	output logic sample_valid_o,
	output logic signed [15:0] inphase_converter_o,
	output logic signed [15:0] quadrature_converter_o
);
	import iqgm_pkg::*;

	// Merges the written byte lanes of a 16-bit register into its old value.
	function automatic logic [15:0] merge_lanes(input logic [15:0] old_value,
		input logic [31:0] data, input logic [3:0] sel);
		logic [15:0] r;
		r = old_value;
		if (sel[0]) begin
			r[7:0] = data[7:0];
		end
		if (sel[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// Bus handshake state.
	iqgm_bus_state_type bus_state_reg;
	iqgm_bus_state_type bus_state_next;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Software-visible storage.
	logic [15:0] igain_reg;
	logic [15:0] igain_next;
	logic [15:0] mixq_reg;
	logic [15:0] mixq_next;
	logic [15:0] phase_word_reg;
	logic [15:0] phase_word_next;

	// Gains actually driving the multipliers.
	logic [10:0] active_igain_reg;
	logic [10:0] active_igain_next;
	logic [10:0] active_qgain_reg;
	logic [10:0] active_qgain_next;

	// Decoded bus request.
	logic bus_req;
	logic bus_take;
	logic bus_write;
	logic [7:0] bus_index;
	logic hit_rsvd_b;
	logic hit_igain;
	logic hit_mixq;
	logic hit_rsvd_e;
	logic hit_phase;
	logic hit_status;
	logic commit;

	// Datapath links.
	logic signed [15:0] gained_i;
	logic signed [15:0] gained_q;
	logic [3:0] mix_mode;
	logic [2:0] mix_phase;
	logic valid_gain_reg;
	logic valid_mix_reg;
	logic [31:0] status_word;

	// A request is taken once, in the idle state, and answered the next cycle.
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign bus_take = bus_req && (bus_state_reg == IQGM_BUS_IDLE);
	assign bus_write = bus_take && wb_we_i;
	assign bus_index = {{IQGM_ADR_LSB{1'b0}}, wb_adr_i[7:IQGM_ADR_LSB]};

	// Address decode by register index.
	assign hit_rsvd_b = (bus_index == IQGM_IDX_RSVD_B);
	assign hit_igain = (bus_index == IQGM_IDX_IGAIN);
	assign hit_mixq = (bus_index == IQGM_IDX_MIXQ);
	assign hit_rsvd_e = (bus_index == IQGM_IDX_RSVD_E);
	assign hit_phase = (bus_index == IQGM_IDX_PHASE);
	assign hit_status = (bus_index == IQGM_IDX_STATUS);

	// Bus state sequencing: idle takes, ack answers and returns to idle.
	always_comb begin
		case (bus_state_reg)
			IQGM_BUS_IDLE: begin
				bus_state_next = bus_req ? IQGM_BUS_ACK : IQGM_BUS_IDLE;
			end
			IQGM_BUS_ACK: begin
				bus_state_next = IQGM_BUS_IDLE;
			end
			default: begin
				bus_state_next = IQGM_BUS_IDLE;
			end
		endcase
	end

	// Writes to the gain registers only update the shadow copies; reserved bits stay clear.
	assign igain_next = (bus_write && hit_igain) ?
		(merge_lanes(igain_reg, wb_dat_i, wb_sel_i) & IQGM_KEEP_IGAIN) : igain_reg; // [RULE_08]
	assign mixq_next = (bus_write && hit_mixq) ?
		(merge_lanes(mixq_reg, wb_dat_i, wb_sel_i) & IQGM_KEEP_MIXQ) : mixq_reg; // [RULE_09]

	// The phase word keeps its fourteen documented bits; the top two are reserved.
	assign phase_word_next = (bus_write && hit_phase) ?
		(merge_lanes(phase_word_reg, wb_dat_i, wb_sel_i) & IQGM_KEEP_PHASE) : phase_word_reg;

	// A write to the phase commit register with a low byte lane selected loads both gains together.
	assign commit = bus_write && hit_phase && (wb_sel_i[1:0] != 2'h0); // [RULE_11]
	assign active_igain_next = commit ? igain_reg[IQGM_GAIN_W-1:0] : active_igain_reg; // [RULE_11]
	assign active_qgain_next = commit ? mixq_reg[IQGM_GAIN_W-1:0] : active_qgain_reg; // [RULE_11]

	// The mixer select acts as soon as it is written.
	assign mix_mode = mixq_reg[IQGM_MIX_LSB +: IQGM_MIX_W]; // [RULE_04] [RULE_05]

	// Status shows the gains in force and the running mixer phase.
	assign status_word = {1'b0, mix_phase, 1'b0, active_qgain_reg, 5'h00, active_igain_reg};

	// Read data selection; unmapped words read as zero and are still acknowledged.
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (bus_take && !wb_we_i) begin
			if (hit_rsvd_b) begin
				rdata_next = {16'h0000, IQGM_RST_RSVD_B}; // [RULE_10]
			end else if (hit_igain) begin
				rdata_next = {16'h0000, igain_reg};
			end else if (hit_mixq) begin
				rdata_next = {16'h0000, mixq_reg};
			end else if (hit_rsvd_e) begin
				rdata_next = {16'h0000, IQGM_RST_RSVD_E};
			end else if (hit_phase) begin
				rdata_next = {16'h0000, phase_word_reg};
			end else if (hit_status) begin
				rdata_next = status_word;
			end else begin
				rdata_next = 32'h0000_0000;
			end
		end
	end

	// Bus handshake registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_reg <= IQGM_BUS_IDLE;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			bus_state_reg <= bus_state_next;
			ack_reg <= bus_take;
			rdata_reg <= rdata_next;
		end
	end

	// Shadow register file with its documented reset values.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			igain_reg <= IQGM_RST_IGAIN; // [RULE_08]
			mixq_reg <= IQGM_RST_MIXQ; // [RULE_07] [RULE_09]
			phase_word_reg <= IQGM_RST_PHASE;
		end else begin
			igain_reg <= igain_next;
			mixq_reg <= mixq_next;
			phase_word_reg <= phase_word_next;
		end
	end

	// Gains in force; unity after reset so the path is transparent.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_igain_reg <= IQGM_RST_IGAIN[IQGM_GAIN_W-1:0]; // [RULE_08]
			active_qgain_reg <= IQGM_RST_MIXQ[IQGM_GAIN_W-1:0]; // [RULE_09]
		end else begin
			active_igain_reg <= active_igain_next;
			active_qgain_reg <= active_qgain_next;
		end
	end

	// In-phase gain multiplier.
	iqgm_gain_scale u_gain_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sample_i(inphase_i),
		.gain_i(active_igain_reg),
		.sample_o(gained_i)
	); // [RULE_01]

	// Quadrature gain multiplier.
	iqgm_gain_scale u_gain_q (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sample_i(quad_i),
		.gain_i(active_qgain_reg),
		.sample_o(gained_q)
	); // [RULE_02]

	// Coarse mixer after gain correction.
	iqgm_coarse_mixer u_mixer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mode_i(mix_mode),
		.valid_i(valid_gain_reg),
		.inphase_i(gained_i),
		.quad_i(gained_q),
		.inphase_o(inphase_converter_o),
		.quad_o(quadrature_converter_o),
		.phase_o(mix_phase)
	); // [RULE_06]

	// Valid follows the two pipeline stages.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_gain_reg <= 1'b0;
			valid_mix_reg <= 1'b0;
		end else begin
			valid_gain_reg <= sample_valid_i;
			valid_mix_reg <= valid_gain_reg;
		end
	end

	assign sample_valid_o = valid_mix_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
endmodule

// [testbench/iqgm_top_properties.sv]
/*
 * Port-level checker for the gain and mixer block.
 * Assumes one clock and a synchronous active-high reset; bound to iqgm_top.
 */
`timescale 1ns/1ns
module iqgm_top_properties (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Sample stream.
	input wire logic sample_valid_i,
	input wire logic sample_valid_o
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire rd_ack = wb_ack_o && !wb_we_i;

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_rsvd_b_zero: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h0b |-> wb_dat_o == 32'h0)
		else $error("reserved word b not zero");
	a_rsvd_e_value: assert property (rd_ack && wb_adr_i[7:2] == 6'h0e |-> wb_dat_o == 32'h400)
		else $error("reserved word e wrong");
	a_igain_rsvd_clear: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h0c |-> wb_dat_o[31:11] == 21'h0)
		else $error("in-phase gain reserved bits set");
	a_mixq_rsvd_clear: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h0d |-> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[11])
		else $error("mixer word reserved bits set");
	a_valid_latency: assert property (sample_valid_i |-> ##2 sample_valid_o)
		else $error("valid sample lost");
	a_idle_latency: assert property (!sample_valid_i |-> ##2 !sample_valid_o)
		else $error("spurious output valid");
endmodule

bind iqgm_top iqgm_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i), .sample_valid_o(sample_valid_o));

// [testbench/iqgm_src_model.sv]
/*
 * Upstream interpolation datapath model: random I/Q samples with gaps.
 * Assumes the bench raises en_i to stream; idle data lines toggle.
 */
`timescale 1ns/1ns
module iqgm_src_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic en_i,
	// Samples out.
	output logic valid_o,
	output logic signed [15:0] i_o,
	output logic signed [15:0] q_o
);
	initial begin
		valid_o = 1'b0;
		i_o = 16'sh0;
		q_o = 16'sh0;
	end
	// One I/Q pair per cycle; when idle the lines show the inverse of the last value.
	always @(posedge clk_i) begin
		if (en_i && !rst_i) begin
			valid_o <= ($urandom % 4) != 0;
			i_o <= $urandom;
			q_o <= $urandom;
		end else begin
			valid_o <= 1'b0;
			i_o <= ~i_o;
			q_o <= ~q_o;
		end
	end
endmodule

// [testbench/tb.sv]
/*
 * Self-checking bench: Wishbone register tests and a sample-level model.
 * Assumes the source model feeds the stream and a 50 MHz clock.
 */
`timescale 1ns/1ns
module tb;
	logic clk_i, rst_i, cyc, stb, we, en;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, dat, r;
	logic ack, vi, vo;
	logic signed [15:0] si, sq, oi, oq;
	int n_fail = 0, num_checks = 0;
	int gi_a = 1024, gq_a = 1024, gi_s = 1024, gq_s = 1024, mode = 0, ph = 0;
	int s1i, s1q, e2i, e2q, s1v = 0, e2v = 0, m;

	iqgm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
		.wb_ack_o(ack), .sample_valid_i(vi), .inphase_i(si), .quad_i(sq),
		.sample_valid_o(vo), .inphase_converter_o(oi), .quadrature_converter_o(oq));
	iqgm_src_model src (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .valid_o(vi), .i_o(si),
		.q_o(sq));

	task stop_test;
		$display("counts checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function int sat(int v);
		return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
	endfunction
	function int step(int md);
		return ((md & 8) ? 1 : 0) + ((md & 4) ? 2 : 0) + ((md & 2) ? 4 : 0) + ((md & 1) ? 6 : 0);
	endfunction
	// One classic cycle: request held until ack is sampled high.
	task wb(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		r = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		wb(a, 1'b1, d);
		if (a == 8'h30) gi_s = d & 16'h7ff;
		if (a == 8'h34) begin
			gq_s = d & 16'h7ff;
			mode = d >> 12;
		end
		if (a == 8'h40) begin
			gi_a = gi_s;
			gq_a = gq_s;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 16'h0);
		chk(r, exp);
	endtask
	task run(int n);
		en <= 1'b1;
		repeat (n) @(posedge clk_i);
		en <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	// Reference pipeline: gain stage, then mixer stage, compared every cycle.
	always @(posedge clk_i) begin
		int ri, rq, t;
		if (rst_i) begin
			s1v = 0;
			e2v = 0;
			ph = 0;
		end else begin
			chk(vo, e2v);
			if (e2v) begin
				chk(oi, e2i);
				chk(oq, e2q);
			end
			ri = s1i;
			rq = s1q;
			if (ph % 2) begin
				t = ri;
				ri = sat(((t - rq) * 23170 + 16384) >>> 15);
				rq = sat(((t + rq) * 23170 + 16384) >>> 15);
			end
			t = ri;
			case (ph / 2)
				1: begin ri = sat(-rq); rq = t; end
				2: begin ri = sat(-ri); rq = sat(-rq); end
				3: begin ri = rq; rq = sat(-t); end
				default: ;
			endcase
			e2i = ri;
			e2q = rq;
			e2v = s1v;
			if (s1v) ph = (ph + step(mode)) % 8;
			s1i = sat((int'(si) * gi_a + 512) >>> 10);
			s1q = sat((int'(sq) * gq_a + 512) >>> 10);
			s1v = vi;
		end
	end

	// Clock generation.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Watchdog well beyond the expected run.
	initial begin
		#400000;
		n_fail++;
		stop_test;
	end
	// Main sequence.
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, en} = 4'h0;
		adr = 8'h0;
		sel = 4'h3;
		wdat = 32'h0;
		m = $urandom(32'hfb06);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		run(30);
		rd(8'h2c, 32'h0);
		rd(8'h30, 32'h400);
		rd(8'h34, 32'h400);
		rd(8'h38, 32'h400);
		rd(8'h44, 32'h0);
		wr(8'h2c, 16'hffff);
		wr(8'h38, 16'h0000);
		rd(8'h2c, 32'h0);
		rd(8'h38, 32'h400);
		$display("test regs done");
		for (int k = 0; k < 3; k++) begin
			wr(8'h30, k == 0 ? 16'hffff : (k == 1 ? 16'h0000 : 16'h0555));
			wr(8'h34, k == 0 ? 16'h0200 : (k == 1 ? 16'h0fff : 16'h0401));
			rd(8'h30, gi_s);
			rd(8'h34, gq_s);
			run(20);
			wr(8'h40, 16'hffff);
			rd(8'h40, 32'h3fff);
			run(40);
			rd(8'h78, (ph << 28) | (gq_a << 16) | gi_a);
		end
		$display("test gain done");
		for (int md = 0; md < 16; md++) begin
			wr(8'h34, (md << 12) | 16'h0400);
			rd(8'h34, (md << 12) | 32'h400);
			run(24);
			rd(8'h78, (ph << 28) | (gq_a << 16) | gi_a);
		end
		$display("test mixer done");
		stop_test;
	end
endmodule
